// [rtl/oss_pkg.sv]
// Constants for the oscillator stop and stabilization block.
// Assumes byte registers on a 32-bit APB, each at four times its index.
package oss_pkg;
    // Register indices; byte address is four times the index
    localparam logic [19:0] OSS_IDX_RUN  = 20'hf_ffa1;
    localparam logic [19:0] OSS_IDX_STAT = 20'hf_ffa2;
    localparam logic [19:0] OSS_IDX_WSEL = 20'hf_ffa3;
    localparam logic [19:0] OSS_IDX_BIT  = 20'hf_ffa8;
    // Reset values
    localparam logic [7:0] OSS_RUN_RST  = 8'hc0;
    localparam logic [7:0] OSS_STAT_RST = 8'h00;
    localparam logic [2:0] OSS_WSEL_RST = 3'h7;
    // Field positions
    localparam int OSS_HALT_BIT  = 7;
    localparam int OSS_OSCH_BIT  = 0;
    localparam int OSS_MASK_LSB  = 8;
    localparam int OSS_ST_READY  = 0;
    localparam int OSS_ST_BUSY   = 1;
    localparam int OSS_ST_DONE   = 2;
    localparam int OSS_ST_MAIN   = 3;
    // Wait thresholds in crystal cycles, code 0 to 7
    localparam logic [18:0] OSS_THR [8] = '{
        19'h0_0100, 19'h0_0200, 19'h0_0400, 19'h0_0800,
        19'h0_2000, 19'h0_8000, 19'h2_0000, 19'h4_0000};
    // Counter states
    typedef enum logic [1:0] {CNT_IDLE, CNT_RUN, CNT_DONE} oss_cnt_t;
endpackage

// [rtl/oss_sync.sv]
// Two-flop synchroniser for one level.
// Assumes the input is asynchronous to clock.
`timescale 1ns/100ps
module oss_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    logic sync_q;
    // First flop feeds only the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end
    assign dout = sync_q;
endmodule

// [rtl/oss_stab_cnt.sv]
// Oscillation stabilization counter with thermometer status.
// Assumes clock is the crystal clock and osc_present is synchronous.
`timescale 1ns/100ps
module oss_stab_cnt #(
    parameter logic [18:0] THR [8] = oss_pkg::OSS_THR
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       clear,
    input  wire logic       start,
    input  wire logic       osc_present,
    input  wire logic [2:0] wait_sel,
    // Status
    output logic [7:0]      status,
    output logic            busy,
    output logic            done
);
    import oss_pkg::*;
    oss_cnt_t    st_q;
    oss_cnt_t    st_d;
    logic [18:0] cnt_q;
    logic [18:0] cnt_d;
    logic [7:0]  stat_q;
    logic [7:0]  stat_d;
    logic [7:0]  hit;

    // Threshold compare, bit 7 is the shortest
    for (genvar k = 0; k < 8; k++) begin : g_thr
        assign hit[7-k] = (cnt_q >= THR[k]);
    end

    // Next state of counter and status
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        stat_d = stat_q | hit;
        if (clear) begin
            st_d   = CNT_IDLE;
            cnt_d  = '0;
            stat_d = OSS_STAT_RST;
        end else if (start) begin
            st_d   = CNT_RUN;
            cnt_d  = '0;
            stat_d = OSS_STAT_RST;
        end else begin
            unique case (st_q)
                CNT_IDLE: begin
                end
                CNT_RUN: begin
                    if (cnt_q >= THR[wait_sel]) begin
                        st_d = CNT_DONE;
                    end else if (osc_present) begin
                        cnt_d = cnt_q + 19'd1;
                    end
                end
                CNT_DONE: begin
                end
            endcase
        end
    end

    // Counter registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q   <= CNT_IDLE;
            cnt_q  <= '0;
            stat_q <= OSS_STAT_RST;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            stat_q <= stat_d;
        end
    end

    assign status = stat_q;
    assign busy   = (st_q == CNT_RUN);
    assign done   = (st_q == CNT_DONE);

    // Count frozen while oscillation absent
    osc_absent_a: assert property (@(posedge clock) disable iff (sys_rst)
        (busy && !osc_present && !clear && !start) |=> $stable(cnt_q))
        else $error("count moved without oscillation");
endmodule

// [rtl/oss_top.sv]
// Oscillator run control and stabilization wait, APB slave.
// Assumes pin mode, main clock flag and STOP events on clock;
// osc_present_pin is asynchronous.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module oss_top #(
    parameter logic [18:0] STAB_THR [8] = oss_pkg::OSS_THR
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [21:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // STOP mode events
    input  wire logic        stop_instr,
    input  wire logic        stop_release,
    // Pin mode and clock select
    input  wire logic        ext_clock_pin_sel,
    input  wire logic        resonator_pin_sel,
    input  wire logic        main_clock_source_flag,
    // Oscillator detect
    input  wire logic        osc_present_pin,
    // Clock controls
    output logic             xtal_osc_enable,
    output logic             ext_clock_accept,
    output logic             onchip_osc_enable,
    output logic             hs_clock_ready
);
    import oss_pkg::*;

    logic       halt_q;
    logic       halt_d;
    logic       osch_q;
    logic       osch_d;
    logic [2:0] wsel_q;
    logic [2:0] wsel_d;
    logic [7:0] rd_q;
    logic [7:0] rd_d;
    logic       xen_q;
    logic       xen_d;
    logic       eacc_q;
    logic       eacc_d;
    logic       hen_q;
    logic       hen_d;
    logic       rdy_q;
    logic       rdy_d;
    logic       sel_run;
    logic       sel_stat;
    logic       sel_wsel;
    logic       sel_bit;
    logic       access;
    logic       wr;
    logic       xtal_mode;
    logic       ext_mode;
    logic       cnt_clear;
    logic       cnt_start;
    logic       osc_sync;
    logic [7:0] status;
    logic       busy;
    logic       done;
    logic [7:0] run_rd;
    logic [7:0] bit_rd;
    logic [7:0] bmask;

    // Pin mode decode
    assign xtal_mode = !ext_clock_pin_sel && resonator_pin_sel;
    assign ext_mode  = ext_clock_pin_sel && resonator_pin_sel;

    // Address decode and bus answer
    assign sel_run  = (paddr == {OSS_IDX_RUN, 2'b00});
    assign sel_stat = (paddr == {OSS_IDX_STAT, 2'b00});
    assign sel_wsel = (paddr == {OSS_IDX_WSEL, 2'b00});
    assign sel_bit  = (paddr == {OSS_IDX_BIT, 2'b00});
    assign access   = psel && penable;
    assign pready   = 1'b1;
    assign pslverr  = access && (!(sel_run || sel_stat || sel_wsel
                      || sel_bit) || (pwrite && sel_stat));
    assign wr       = access && pwrite && !pslverr;
    assign bmask    = pwdata[OSS_MASK_LSB +: 8];

    // Read views
    assign run_rd = {halt_q, 1'b1, 5'b0_0000, osch_q};
    always_comb begin
        bit_rd = 8'h00;
        bit_rd[OSS_ST_READY] = rdy_q;
        bit_rd[OSS_ST_BUSY]  = busy;
        bit_rd[OSS_ST_DONE]  = done;
        bit_rd[OSS_ST_MAIN]  = main_clock_source_flag;
    end

    // Register writes and read capture
    always_comb begin
        halt_d = halt_q;
        osch_d = osch_q;
        wsel_d = wsel_q;
        rd_d   = rd_q;
        if (wr && sel_run && pstrb[0]) begin
            halt_d = pwdata[OSS_HALT_BIT];
            osch_d = pwdata[OSS_OSCH_BIT];
        end
        if (wr && sel_bit && pstrb[0] && pstrb[1]) begin
            if (bmask[OSS_HALT_BIT]) begin
                halt_d = pwdata[OSS_HALT_BIT];
            end
            if (bmask[OSS_OSCH_BIT]) begin
                osch_d = pwdata[OSS_OSCH_BIT];
            end
        end
        if (wr && sel_wsel && pstrb[0]) begin
            wsel_d = pwdata[2:0];
        end
        if (psel && !penable) begin
            rd_d = sel_run  ? run_rd :
                   sel_stat ? status :
                   sel_wsel ? {5'b0_0000, wsel_q} :
                   sel_bit  ? bit_rd : 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            halt_q <= OSS_RUN_RST[OSS_HALT_BIT];
            osch_q <= OSS_RUN_RST[OSS_OSCH_BIT];
            wsel_q <= OSS_WSEL_RST;
            rd_q   <= 8'h00;
        end else begin
            halt_q <= halt_d;
            osch_q <= osch_d;
            wsel_q <= wsel_d;
            rd_q   <= rd_d;
        end
    end
    assign prdata = {24'h00_0000, rd_q};

    // Counter start and clear events
    assign cnt_clear = stop_instr || halt_d;
    assign cnt_start = (halt_q && !halt_d && xtal_mode)
                       || stop_release;

    oss_sync u_osc_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .din     (osc_present_pin),
        .dout    (osc_sync)
    );

    oss_stab_cnt #(
        .THR (STAB_THR)
    ) u_cnt (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .clear       (cnt_clear),
        .start       (cnt_start),
        .osc_present (osc_sync),
        .wait_sel    (wsel_q),
        .status      (status),
        .busy        (busy),
        .done        (done)
    );

    // Clock control outputs
    always_comb begin
        xen_d  = xtal_mode && !halt_q;
        eacc_d = ext_mode && !halt_q;
        hen_d  = !osch_q;
        rdy_d  = !halt_q && (ext_mode || (xtal_mode && done));
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            xen_q  <= 1'b0;
            eacc_q <= 1'b0;
            hen_q  <= 1'b1;
            rdy_q  <= 1'b0;
        end else begin
            xen_q  <= xen_d;
            eacc_q <= eacc_d;
            hen_q  <= hen_d;
            rdy_q  <= rdy_d;
        end
    end
    assign xtal_osc_enable   = xen_q;
    assign ext_clock_accept  = eacc_q;
    assign onchip_osc_enable = hen_q;
    assign hs_clock_ready    = rdy_q;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // Start write of the halt bit, then a fresh count
    sequence s_halt_clear;
        wr && sel_run && pstrb[0] && !pwdata[OSS_HALT_BIT] && halt_q;
    endsequence
    sequence s_count_begins;
        busy && status == 8'h00;
    endsequence

    // Reset values seen on the first free cycle
    reset_value_a: assert property (
        $fell(sys_rst) |-> (run_rd == OSS_RUN_RST && wsel_q == OSS_WSEL_RST))
        else $error("run control not C0H after reset");

    // High-speed clock paths off while halted
    halt_xtal_a: assert property (
        halt_q |=> !xtal_osc_enable && !ext_clock_accept)
        else $error("high-speed clock active while halted");

    // Crystal runs once released in crystal mode
    xtal_run_a: assert property (
        (xtal_mode && !halt_q) |=> xtal_osc_enable)
        else $error("crystal not enabled");

    // External clock taken at once, no wait needed
    ext_run_a: assert property (
        (ext_mode && !halt_q) |=> ext_clock_accept && hs_clock_ready)
        else $error("external clock not accepted");

    // Input port mode drives no high-speed clock
    port_mode_a: assert property (
        !(xtal_mode || ext_mode)
        |=> !xtal_osc_enable && !ext_clock_accept && !hs_clock_ready)
        else $error("clock active in input port mode");

    // On-chip oscillator follows its halt bit
    osc_halt_a: assert property (
        osch_q |=> !onchip_osc_enable)
        else $error("on-chip oscillator enabled while halted");
    osc_run_a: assert property (
        !osch_q |=> onchip_osc_enable)
        else $error("on-chip oscillator not enabled");

    // Byte write lands both live bits
    run_write_a: assert property (
        (wr && sel_run && pstrb[0]) |=> halt_q == $past(pwdata[OSS_HALT_BIT])
        && osch_q == $past(pwdata[OSS_OSCH_BIT]))
        else $error("run control byte write lost");

    // Bit access touches only the masked bits
    bit_mask_a: assert property (
        (wr && sel_bit && !bmask[OSS_HALT_BIT]) |=> $stable(halt_q))
        else $error("masked bit changed");
    bit_write_a: assert property (
        (wr && sel_bit && pstrb[0] && pstrb[1] && bmask[OSS_HALT_BIT])
        |=> halt_q == $past(pwdata[OSS_HALT_BIT]))
        else $error("masked halt bit write lost");

    // Status cleared by halt and STOP, counter parked
    status_clear_a: assert property (
        (halt_q || $past(stop_instr)) |-> status == 8'h00)
        else $error("status not cleared");
    clear_stop_a: assert property (
        stop_instr |=> !busy && !done)
        else $error("counter still active after STOP");

    // Crystal start kicks off a fresh count
    count_start_a: assert property (
        s_halt_clear ##0 (xtal_mode && !stop_instr) |=> s_count_begins)
        else $error("count did not start");

    // Thermometer fills from the shortest threshold
    thermo_order_a: assert property (
        (status[6:0] & ~status[7:1]) == 7'h00)
        else $error("status bits out of order");

    // Status refuses writes
    status_ro_a: assert property (
        (access && pwrite && sel_stat) |-> pslverr ##1 $stable(status)
        or ##1 status == 8'h00 || busy)
        else $error("status write accepted");

    // Count ends at the selected length
    stop_len_a: assert property (
        done |-> status == ~(8'hff >> ({1'b0, wsel_q} + 4'd1)))
        else $error("status beyond selected length");

    // Wait select takes whole-byte writes only
    wsel_write_a: assert property (
        (wr && sel_wsel && pstrb[0]) |=> wsel_q == $past(pwdata[2:0]))
        else $error("wait select write lost");
    byte_only_a: assert property (
        (wr && sel_wsel && !pstrb[0]) |=> $stable(wsel_q))
        else $error("wait select took partial write");

    // Crystal clock held back until the wait is over
    hold_off_a: assert property (
        (xtal_mode && !done) |=> !hs_clock_ready)
        else $error("crystal clock released early");
    ready_done_a: assert property (
        (xtal_mode && !halt_q && done) |=> hs_clock_ready)
        else $error("crystal clock not released after wait");

    // Read views captured at the setup cycle
    main_flag_a: assert property (
        (psel && !penable && sel_bit)
        |=> rd_q[OSS_ST_MAIN] == $past(main_clock_source_flag))
        else $error("main clock flag not shown");
    fixed_bits_a: assert property (
        (psel && !penable && sel_run) |=> rd_q[6:1] == 6'h20)
        else $error("fixed run control bits wrong");
endmodule

// [tb/oss_top_bench.sv]
// Self-checking bench for the oscillator stop and stabilization block.
// Assumes oss_top with zero-wait APB and shortened wait thresholds.
`timescale 1ns/100ps
module oss_top_bench;
    import oss_pkg::*;
    localparam logic [18:0] THR [8] = '{4, 8, 16, 32, 64, 128, 256, 512};
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [21:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = '0;
    logic        pready, pslverr, err;
    logic        stop_instr = 1'b0, stop_release = 1'b0;
    logic        ext_clock_pin_sel = 1'b0, resonator_pin_sel = 1'b0;
    logic        main_clock_source_flag = 1'b0, osc_present_pin = 1'b0;
    logic        xtal_osc_enable, ext_clock_accept;
    logic        onchip_osc_enable, hs_clock_ready;
    int          n_mismatch = 0, total_checks = 0;

    // Device under test with short thresholds
    oss_top #(.STAB_THR(THR)) oss_top_inst (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_instr(stop_instr), .stop_release(stop_release),
        .ext_clock_pin_sel(ext_clock_pin_sel),
        .resonator_pin_sel(resonator_pin_sel),
        .main_clock_source_flag(main_clock_source_flag),
        .osc_present_pin(osc_present_pin),
        .xtal_osc_enable(xtal_osc_enable),
        .ext_clock_accept(ext_clock_accept),
        .onchip_osc_enable(onchip_osc_enable),
        .hs_clock_ready(hs_clock_ready));

    // 40 MHz clock
    always #12.5 clock = ~clock;

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [19:0] idx,
                       input logic [31:0] wd, input logic [3:0] st);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge clock);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [19:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000, 4'h0);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0000_0000);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Bounded wait for the high-speed ready level
    task automatic wait_rdy();
        int i;
        i = 0;
        while (hs_clock_ready !== 1'b1 && i < 3000) begin
            @(posedge clock);
            i++;
        end
        chk({31'h0, hs_clock_ready}, 32'h0000_0001);
    endtask

    task automatic t_reset();
        rdchk(OSS_IDX_RUN, 32'h0000_00c0);
        rdchk(OSS_IDX_STAT, 32'h0000_0000);
        rdchk(OSS_IDX_WSEL, 32'h0000_0007);
        chk({29'h0, onchip_osc_enable, xtal_osc_enable, hs_clock_ready},
            32'h0000_0004);
    endtask

    // Fixed bits, refused accesses, byte-only wait select
    task automatic t_regs();
        main_clock_source_flag <= 1'b1;
        apb(1'b1, OSS_IDX_RUN, 32'h0000_007f, 4'h1);
        rdchk(OSS_IDX_RUN, 32'h0000_0041);
        idle(2);
        chk({31'h0, onchip_osc_enable}, 32'h0000_0000);
        main_clock_source_flag <= 1'b0;
        apb(1'b1, OSS_IDX_RUN, 32'h0000_00c0, 4'h1);
        idle(2);
        chk({31'h0, onchip_osc_enable}, 32'h0000_0001);
        apb(1'b1, OSS_IDX_STAT, 32'h0000_00ff, 4'h1);
        chk({31'h0, err}, 32'h0000_0001);
        rdchk(OSS_IDX_STAT, 32'h0000_0000);
        apb(1'b0, 20'hf_ffa5, 32'h0000_0000, 4'h0);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, OSS_IDX_WSEL, 32'h0000_0002, 4'h0);
        rdchk(OSS_IDX_WSEL, 32'h0000_0007);
        apb(1'b1, OSS_IDX_WSEL, 32'h0000_00fa, 4'h1);
        rdchk(OSS_IDX_WSEL, 32'h0000_0002);
    endtask

    // Single-bit writes leave the other run control bit alone
    task automatic t_bits();
        main_clock_source_flag <= 1'b1;
        apb(1'b1, OSS_IDX_BIT, 32'h0000_0101, 4'h3);
        rdchk(OSS_IDX_RUN, 32'h0000_00c1);
        main_clock_source_flag <= 1'b0;
        apb(1'b1, OSS_IDX_BIT, 32'h0000_0100, 4'h3);
        rdchk(OSS_IDX_RUN, 32'h0000_00c0);
        apb(1'b1, OSS_IDX_BIT, 32'h0000_8000, 4'h3);
        rdchk(OSS_IDX_RUN, 32'h0000_0040);
        apb(1'b1, OSS_IDX_BIT, 32'h0000_8080, 4'h3);
        rdchk(OSS_IDX_RUN, 32'h0000_00c0);
    endtask

    // Every wait code: clear, start, thermometer result
    task automatic t_codes();
        ext_clock_pin_sel <= 1'b0;
        resonator_pin_sel <= 1'b1;
        osc_present_pin <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, OSS_IDX_RUN, 32'h0000_00c0, 4'h1);
            rdchk(OSS_IDX_STAT, 32'h0000_0000);
            apb(1'b1, OSS_IDX_WSEL, c, 4'h1);
            apb(1'b1, OSS_IDX_RUN, 32'h0000_0040, 4'h1);
            idle(2);
            chk({30'h0, xtal_osc_enable, hs_clock_ready},
                32'h0000_0002);
            wait_rdy();
            rdchk(OSS_IDX_STAT, {24'h0, 8'hff << (7 - c)});
            idle(THR[7]);
            rdchk(OSS_IDX_STAT, {24'h0, 8'hff << (7 - c)});
        end
    endtask

    // No oscillation, no count; STOP clears, release restarts
    task automatic t_absent_stop();
        apb(1'b1, OSS_IDX_RUN, 32'h0000_00c0, 4'h1);
        apb(1'b1, OSS_IDX_WSEL, 32'h0000_0001, 4'h1);
        osc_present_pin <= 1'b0;
        apb(1'b1, OSS_IDX_RUN, 32'h0000_0040, 4'h1);
        idle(100);
        rdchk(OSS_IDX_STAT, 32'h0000_0000);
        osc_present_pin <= 1'b1;
        wait_rdy();
        rdchk(OSS_IDX_STAT, 32'h0000_00c0);
        stop_instr <= 1'b1;
        @(posedge clock);
        stop_instr <= 1'b0;
        rdchk(OSS_IDX_STAT, 32'h0000_0000);
        stop_release <= 1'b1;
        @(posedge clock);
        stop_release <= 1'b0;
        idle(40);
        rdchk(OSS_IDX_STAT, 32'h0000_00c0);
    endtask

    // External clock mode and main clock flag view
    task automatic t_ext();
        apb(1'b1, OSS_IDX_RUN, 32'h0000_00c0, 4'h1);
        ext_clock_pin_sel <= 1'b1;
        resonator_pin_sel <= 1'b1;
        apb(1'b1, OSS_IDX_RUN, 32'h0000_0040, 4'h1);
        idle(3);
        chk({29'h0, ext_clock_accept, xtal_osc_enable, hs_clock_ready},
            32'h0000_0005);
        main_clock_source_flag <= 1'b1;
        idle(1);
        apb(1'b0, OSS_IDX_BIT, 32'h0000_0000, 4'h0);
        chk({31'h0, rd[OSS_ST_MAIN]}, 32'h0000_0001);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        idle(16);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_bits();
        t_codes();
        t_absent_stop();
        t_ext();
        end_of_test();
    end

    // Watchdog
    initial begin
        #(25 * 60000);
        n_mismatch++;
        end_of_test();
    end
endmodule
